// >>> asc_top.sv
// Scan-sequence configuration decoder and conversion sequencer behind a 3-wire serial link
//
// How it works
// R01: Code 10100 in bits 15:11 writes the upper channel mask.
// R02: Upper mask bits 10..3 enable inputs 15..8, bit 10 is input 15.
// R03: Code 10101 in bits 15:11 writes the lower channel mask.
// R04: Lower mask bits 10..3 enable inputs 7..0, bit 3 is input 0.
// R05: Enable bits reset to 0; zero skips a channel; bits 2:0 unused.
// R06: Code 10110 in bits 15:11 writes the sequence length.
// R07: Length field bits 10:3, reset 0, gives field plus one conversions.
// R08: Word with MSB 1 is a configuration write.
// R09: Word with MSB 0 is a mode-control write.
// R10: Mode word mid-sequence: finish conversion, execute at next chip-select fall.
// R11: Config word mid-sequence: finish present conversion in existing scan mode.
// R12: After mid-sequence config, data invalid until a new mode word.
// R13: Started sequence returns results from the first pattern entry.
// R14: Host reloads the whole pattern when changing the length.
// R15: One 16-bit MSB-first word per frame, taken at chip-select rise.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_top import asc_pkg::*; (
  input wire logic clk_i,               // Core clock, 250 MHz
  input wire logic reset_n_i,           // Async reset, active low
  input wire logic sclk_i,              // Serial clock from host
  input wire logic cs_n_i,              // Chip select, active low
  input wire logic din_i,               // Serial data in
  output logic [7:0] upper_mask_o,      // Enables for inputs 15..8
  output logic [7:0] lower_mask_o,      // Enables for inputs 7..0
  output logic [7:0] seq_len_o,         // Sequence length field
  output logic busy_o,                  // Sequence running
  output logic conv_start_o,            // One-cycle start of a conversion
  output logic [3:0] channel_o,         // Input being converted
  output logic data_valid_o,            // Serial output data trustworthy
  output logic power_down_o             // Last mode word asked for power down
);
  localparam int conv_cycles_lp = (`ASC_CONV_TIME_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS;
  localparam logic [7:0] conv_last_lp = 8'(conv_cycles_lp - 1);
  localparam int wait_max_lp = conv_cycles_lp + 2;

  logic rst_n;
  logic [15:0] link_word;
  logic link_done;
  logic cs_s;
  logic done_s;
  logic cs_rise;
  logic cs_fall;
  logic done_rise;
  logic commit;
  logic [15:0] cmd_word;
  logic [4:0] sel;
  logic [7:0] field;
  logic is_cfg;
  logic conv_end;
  logic [15:0] scan_mask;
  logic [4:0] first_hit;
  logic [4:0] next_hit;
  asc_top_state_type r_reg;
  asc_top_state_type r_next;

  // Next enabled channel after cur, wrapping; bit 4 flags that one was found
  function automatic logic [4:0] next_enabled(input logic [15:0] mask, input logic [3:0] cur);
    logic [4:0] res;
    logic [3:0] c;
    res = 5'h00;
    for (int k = 16; k >= 1; k--) begin
      c = cur + 4'(k);
      if (mask[c]) begin
        res = {1'b1, c};
      end
    end
    return res;
  endfunction

  // Reset release through two flops
  asc_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // Link-clock receiver
  asc_frame_rx u_rx (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .word_o(link_word),
    .done_o(link_done)
  );

  // Word-complete flag crosses as a level; it idles low, like its reset value
  asc_sync2 #(.WIDTH(1)) u_link_sync (
    .clk_i(clk_i),
    .reset_n_i(rst_n),
    .d_i(link_done),
    .q_o(done_s)
  );

  // Chip select idles high, so its synchroniser stays out of reset: a cleared
  // stage would read as a select rise just after every reset
  asc_sync2 #(.WIDTH(1)) u_cs_sync (
    .clk_i(clk_i),
    .reset_n_i(1'b1),
    .d_i(cs_n_i),
    .q_o(cs_s)
  );

  // Edge events and command decode; the shifted word is only read after its flag has crossed
  always_comb begin
    cs_rise = cs_s && !r_reg.cs_prev;
    cs_fall = !cs_s && r_reg.cs_prev;
    done_rise = done_s && !r_reg.done_prev;
    cmd_word = done_rise ? link_word : r_reg.held;
    commit = cs_rise && (r_reg.held_ok || done_rise); // R15
    sel = cmd_word[`ASC_SEL_HI:`ASC_SEL_LO];
    field = cmd_word[`ASC_FIELD_HI:`ASC_FIELD_LO];
    is_cfg = cmd_word[`ASC_CFG_BIT];
    conv_end = (r_reg.st == ASC_CONV) && (r_reg.cyc == conv_last_lp);
    scan_mask = {r_reg.upper, r_reg.lower}; // R02 R04
    first_hit = next_enabled(scan_mask, 4'hF); // R13
    next_hit = next_enabled(scan_mask, r_reg.chan);
  end

  // Register writes and the conversion sequencer
  always_comb begin
    r_next = r_reg;
    r_next.conv_start = 1'b0;
    r_next.cs_prev = cs_s;
    r_next.done_prev = done_s;
    if (done_rise) begin
      r_next.held = link_word;
      r_next.held_ok = 1'b1;
    end
    // A frame without sixteen bits leaves nothing to commit
    if (cs_rise) begin
      r_next.held_ok = 1'b0;
    end
    if (commit) begin
      if (is_cfg) begin // R08
        case (sel)
          `ASC_UPPER_MASK_CODE: r_next.upper = field; // R01 R02
          `ASC_LOWER_MASK_CODE: r_next.lower = field; // R03 R04
          `ASC_LENGTH_CODE: r_next.seqlen = field; // R06 R07
          default: r_next.upper = r_reg.upper;
        endcase
        // The channel in flight keeps going; the scan ends after it and output goes stale
        if (r_reg.st == ASC_CONV) begin
          r_next.stop_after = 1'b1; // R11
          r_next.valid = 1'b0; // R12
        end
      end else begin
        r_next.pend = 1'b1; // R09
        r_next.pend_start = cmd_word[`ASC_START_BIT];
      end
    end
    case (r_reg.st)
      ASC_IDLE: begin
        // A pending instruction waits for the next chip-select fall
        if (cs_fall && r_reg.pend) begin // R10
          r_next.pend = 1'b0;
          if (r_reg.pend_start) begin
            r_next.pdown = 1'b0;
            if (first_hit[4]) begin
              r_next.st = ASC_CONV;
              r_next.chan = first_hit[3:0]; // R13
              r_next.idx = 8'h00;
              r_next.cyc = 8'h00;
              r_next.conv_start = 1'b1;
              r_next.busy = 1'b1;
              r_next.valid = 1'b1;
            end
          end else begin
            r_next.pdown = 1'b1;
          end
        end
      end
      ASC_CONV: begin
        if (conv_end) begin
          // Stop on length reached, a new instruction, or a mid-run config write;
          // a word committed in this very cycle counts too, else one more channel would slip out
          if (r_reg.stop_after || r_reg.pend || commit || (r_reg.idx == r_reg.seqlen)) begin // R07 R10 R11
            r_next.st = ASC_IDLE;
            r_next.busy = 1'b0;
            r_next.stop_after = 1'b0;
          end else begin
            r_next.idx = r_reg.idx + 8'h01;
            r_next.chan = next_hit[3:0]; // R05
            r_next.cyc = 8'h00;
            r_next.conv_start = 1'b1;
          end
        end else begin
          r_next.cyc = r_reg.cyc + 8'h01;
        end
      end
      default: begin
        r_next.st = ASC_IDLE;
      end
    endcase
  end

  // State register; enables and length come up cleared
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.upper <= `ASC_MASK_RESET; // R05
      r_reg.lower <= `ASC_MASK_RESET; // R05
      r_reg.seqlen <= `ASC_LENGTH_RESET; // R07
      r_reg.cs_prev <= 1'b1; // Select pin idles high
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign upper_mask_o = r_reg.upper;
  assign lower_mask_o = r_reg.lower;
  assign seq_len_o = r_reg.seqlen;
  assign busy_o = r_reg.busy;
  assign conv_start_o = r_reg.conv_start;
  assign channel_o = r_reg.chan;
  assign data_valid_o = r_reg.valid;
  assign power_down_o = r_reg.pdown;

  default clocking asc_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence cfg_mid_run_s;
    commit && is_cfg && (r_reg.st == ASC_CONV);
  endsequence

  sequence start_exec_s;
    cs_fall && r_reg.pend && r_reg.pend_start && (r_reg.st == ASC_IDLE) && first_hit[4];
  endsequence

  sequence stop_exec_s;
    cs_fall && r_reg.pend && !r_reg.pend_start && (r_reg.st == ASC_IDLE);
  endsequence

  upper_mask_write_a: assert property (commit && is_cfg && sel == 5'h14 |=> upper_mask_o == $past(field)) // R01
    else $error("upper mask not written from select 10100");
  lower_mask_write_a: assert property (commit && is_cfg && sel == 5'h15 |=> lower_mask_o == $past(field)) // R03
    else $error("lower mask not written from select 10101");
  length_write_a: assert property (commit && is_cfg && sel == 5'h16 |=> seq_len_o == $past(field)) // R06
    else $error("length not written from select 10110");
  mode_keeps_cfg_a: assert property (commit && !is_cfg |=> $stable(upper_mask_o) && $stable(seq_len_o)) // R09
    else $error("mode word altered configuration");
  reset_clear_a: assert property ($rose(rst_n) |-> upper_mask_o == 8'h00 && lower_mask_o == 8'h00) // R05
    else $error("enables not cleared by reset");
  skip_disabled_a: assert property (conv_start_o |-> scan_mask[channel_o]) // R05
    else $error("disabled channel converted");
  length_end_a: assert property (conv_end && r_reg.idx == r_reg.seqlen |=> !busy_o) // R07
    else $error("sequence ran past its length");
  config_only_a: assert property ($changed(upper_mask_o) |-> $past(commit && is_cfg)) // R08
    else $error("mask changed without configuration word");
  mode_defer_a: assert property (r_reg.pend && busy_o |-> ##[0:wait_max_lp] !busy_o) // R10
    else $error("mode word did not end the running sequence");
  cfg_finish_a: assert property (cfg_mid_run_s |=> (!conv_start_o && $stable(channel_o)) until !busy_o) // R11
    else $error("new conversion after mid-run configuration");
  cfg_bound_a: assert property (cfg_mid_run_s |-> ##[1:wait_max_lp] !busy_o) // R11
    else $error("mid-run configuration did not end sequence");
  cfg_invalid_a: assert property (cfg_mid_run_s |=> !data_valid_o) // R12
    else $error("data still valid after mid-run configuration");
  first_entry_a: assert property (start_exec_s |=> conv_start_o && channel_o == $past(first_hit[3:0])) // R13
    else $error("sequence did not start at first entry");
  commit_at_rise_a: assert property ($changed(seq_len_o) |-> $past(cs_rise)) // R15
    else $error("length changed away from chip-select rise");

  // Words that must leave the configuration alone
  lower_keep_a: assert property (commit && !is_cfg |=> $stable(lower_mask_o)) // R09
    else $error("mode word altered lower mask");
  unused_code_a: assert property (commit && is_cfg && !(sel inside {5'h14, 5'h15, 5'h16}) |=> // R08
    $stable({upper_mask_o, lower_mask_o, seq_len_o}))
    else $error("unused select code changed configuration");
  short_frame_a: assert property (cs_rise && !r_reg.held_ok && !done_rise |=> $stable(upper_mask_o)) // R15
    else $error("short frame changed configuration");

  // Sequencer starts, spacing and ends
  conv_gap_a: assert property (conv_start_o |=> !conv_start_o [*8]) // R07
    else $error("conversion restarted too soon");
  conv_busy_a: assert property (conv_start_o |-> busy_o) // R07
    else $error("conversion started outside a sequence");
  busy_rise_a: assert property ($rose(busy_o) |-> conv_start_o && data_valid_o && !power_down_o) // R13
    else $error("sequence start incomplete");
  start_at_fall_a: assert property ($rose(busy_o) |-> $past(cs_fall)) // R10
    else $error("sequence started away from chip-select fall");
  valid_on_start_a: assert property ($rose(data_valid_o) |-> $rose(busy_o)) // R12
    else $error("data valid without a start");
  stop_exec_a: assert property (stop_exec_s |=> power_down_o && !busy_o) // R09
    else $error("power-down mode word not executed");
  channel_hold_a: assert property (!conv_start_o |-> $stable(channel_o)) // R13
    else $error("channel moved without a conversion start");
  cfg_idle_valid_a: assert property (commit && is_cfg && (r_reg.st == ASC_IDLE) |=> $stable(data_valid_o)) // R12
    else $error("idle configuration changed data valid");

  // Commit timing and reset values
  upper_at_rise_a: assert property ($changed(upper_mask_o) |-> $past(cs_rise)) // R15
    else $error("upper mask changed away from chip-select rise");
  lower_at_rise_a: assert property ($changed(lower_mask_o) |-> $past(cs_rise)) // R15
    else $error("lower mask changed away from chip-select rise");
  reset_length_a: assert property ($rose(rst_n) |-> seq_len_o == 8'h00 && !busy_o) // R07
    else $error("length or busy not cleared by reset");
endmodule
`default_nettype wire

// >>> asc_defines.svh
// Constants for the scan-sequence configuration decoder: codes, field positions, resets, timing
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_WORD_BITS 16
`define ASC_CFG_BIT 15
`define ASC_SEL_HI 15
`define ASC_SEL_LO 11
`define ASC_FIELD_HI 10
`define ASC_FIELD_LO 3
`define ASC_START_BIT 10

`define ASC_UPPER_MASK_CODE 5'h14
`define ASC_LOWER_MASK_CODE 5'h15
`define ASC_LENGTH_CODE 5'h16

`define ASC_MASK_RESET 8'h00
`define ASC_LENGTH_RESET 8'h00

`define ASC_CLK_PERIOD_NS 4
`define ASC_CONV_TIME_NS 64

`endif

// >>> asc_pkg.sv
// Types shared by the scan-sequence configuration decoder
package asc_pkg;

  typedef enum logic [0:0] {
    ASC_IDLE = 1'b0,
    ASC_CONV = 1'b1
  } asc_state_type;

  typedef struct packed {
    asc_state_type st;
    logic [7:0] cyc;
    logic [7:0] idx;
    logic [3:0] chan;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] seqlen;
    logic pend;
    logic pend_start;
    logic stop_after;
    logic valid;
    logic pdown;
    logic busy;
    logic conv_start;
    logic held_ok;
    logic [15:0] held;
    logic cs_prev;
    logic done_prev;
  } asc_top_state_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] sh;
    logic done;
  } asc_rx_state_type;

endpackage

// >>> asc_sync2.sv
// Two-flop level synchroniser, also used as reset release stage
`timescale 1ns/1ps
`default_nettype none
module asc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,               // Destination clock
  input wire logic reset_n_i,           // Async reset, active low
  input wire logic [WIDTH-1:0] d_i,     // Asynchronous level in
  output logic [WIDTH-1:0] q_o          // Synchronised level out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } asc_sync_state_type;

  asc_sync_state_type r_reg;
  asc_sync_state_type r_next;

  // First stage feeds only the second stage
  always_comb begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;
endmodule
`default_nettype wire

// >>> asc_frame_rx.sv
// Link-clock side: shifts one 16-bit command word in per chip-select frame
`timescale 1ns/1ps
`default_nettype none
module asc_frame_rx import asc_pkg::*; (
  input wire logic sclk_i,              // Serial clock from host
  input wire logic cs_n_i,              // Chip select, active low
  input wire logic din_i,               // Serial data, MSB first
  output logic [15:0] word_o,           // Shifted word
  output logic done_o                   // Sixteen bits received in this frame
);
  asc_rx_state_type r_reg;
  asc_rx_state_type r_next;

  // Shift on rising sclk; bits past the sixteenth are ignored
  always_comb begin
    r_next = r_reg;
    if (r_reg.cnt < 5'h10) begin
      r_next.sh = {r_reg.sh[14:0], din_i}; // R15
      r_next.cnt = r_reg.cnt + 5'h01;
      if (r_reg.cnt == 5'h0F) begin
        r_next.done = 1'b1;
      end
    end
  end

  // Chip select high clears the frame; sclk is idle then, so this is the only way to end it
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign word_o = r_reg.sh;
  assign done_o = r_reg.done;
endmodule
`default_nettype wire

// >>> asc_host_model.sv
// Host-side model of the 3-wire serial link: frames one command word per chip-select low
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  output logic sclk_o, // Serial clock, still outside frames
  output logic cs_n_o, // Chip select, active low
  output logic din_o   // Serial data, MSB first
);
  // Idle link: chip select high, clock parked low; the receiver has no reset of its own,
  // so a select rise just after start clears it before the first frame
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    din_o = 1'b0;
    #1 cs_n_o = 1'b1;
  end

  // One frame; nbits below 16 makes a deliberately short frame
  task automatic send(input logic [15:0] w, input int nbits);
    cs_n_o = 1'b0;
    #20;
    // Bit 15 goes first; it selects configuration or mode control
    for (int i = 0; i < nbits; i++) begin
      din_o = w[15 - i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    // Hold chip select past the last edge so the completion flag can cross
    #20;
    din_o = ~din_o; // Released line shows no stale value
    cs_n_o = 1'b1;
    #25;
  endtask
  // Select codes and pattern reloads come from the caller's words
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the scan-sequence configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module tb;
  logic clk_i, reset_n_i;
  wire logic sclk, cs_n, din;
  logic [7:0] upper_mask_o, lower_mask_o, seq_len_o;
  logic busy_o, conv_start_o, data_valid_o, power_down_o;
  logic [3:0] channel_o;
  logic [3:0] chq[$];
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  asc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  asc_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .upper_mask_o(upper_mask_o), .lower_mask_o(lower_mask_o), .seq_len_o(seq_len_o), .busy_o(busy_o),
    .conv_start_o(conv_start_o), .channel_o(channel_o), .data_valid_o(data_valid_o),
    .power_down_o(power_down_o));

  // Core clock at 4 ns
  initial clk_i = 1'b0;
  always #2 clk_i = ~clk_i;

  // Record the channel of every conversion start; cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) chq.push_back(channel_o);
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Bounded wait for the sequencer to go idle
  task automatic wait_idle();
    int k;
    for (k = 0; k < 6000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    check(k < 6000, 1);
  endtask

  task automatic cfg(input logic [4:0] code, input logic [7:0] f);
    host.send({code, f, 3'h7}, 16);
    wait_clk(8);
  endtask

  // Start word, then a bare frame whose chip-select fall executes it
  task automatic start_seq();
    host.send(16'h0400, 16);
    wait_clk(8);
    check(busy_o, 0);
    chq.delete();
    host.send(16'h0000, 0);
    wait_clk(8);
  endtask

  task automatic t_reset();
    check({upper_mask_o, lower_mask_o, seq_len_o}, 0);
    check({busy_o, data_valid_o, power_down_o}, 0);
  endtask

  task automatic t_config();
    cfg(`ASC_UPPER_MASK_CODE, 8'hA5);
    check(upper_mask_o, 8'hA5);
    check(lower_mask_o, 8'h00);
    cfg(`ASC_LOWER_MASK_CODE, 8'h81);
    check(lower_mask_o, 8'h81);
    cfg(`ASC_LENGTH_CODE, 8'h02);
    check(seq_len_o, 8'h02);
    cfg(5'h17, 8'hFF);
    check({upper_mask_o, lower_mask_o, seq_len_o}, 24'hA58102);
    host.send({`ASC_UPPER_MASK_CODE, 8'h00, 3'h0}, 15);
    wait_clk(8);
    check(upper_mask_o, 8'hA5);
  endtask

  // Inputs enabled: 0,7 (lower) and 8,10,13,15 (upper); length field 2 gives three
  task automatic t_run();
    start_seq();
    check({busy_o, data_valid_o, power_down_o}, 3'b110);
    wait_idle();
    check(chq.size(), 3);
    check({chq[0], chq[1], chq[2]}, 12'h078);
    cfg(`ASC_LENGTH_CODE, 8'h00);
    cfg(`ASC_UPPER_MASK_CODE, 8'hA5);
    cfg(`ASC_LOWER_MASK_CODE, 8'h81);
    start_seq();
    wait_idle();
    check(chq.size(), 1);
  endtask

  // Configuration write mid-run: sequence stops, data stays invalid until a start
  task automatic t_midcfg();
    cfg(`ASC_LENGTH_CODE, 8'hFF);
    cfg(`ASC_UPPER_MASK_CODE, 8'hA5);
    cfg(`ASC_LOWER_MASK_CODE, 8'h81);
    start_seq();
    check(busy_o, 1);
    cfg(`ASC_LOWER_MASK_CODE, 8'h01);
    wait_idle();
    check(chq.size() < 20, 1);
    check({data_valid_o, lower_mask_o}, 9'h001);
    host.send(16'h0000, 0);
    wait_clk(8);
    check(data_valid_o, 0);
    start_seq();
    check({data_valid_o, chq[0]}, 5'h10);
  endtask

  // Mode word mid-run: conversion finishes, word waits for the next chip-select fall
  task automatic t_midmode();
    host.send(16'h0000, 16);
    wait_idle();
    check(chq.size() < 20, 1);
    check(power_down_o, 0);
    host.send(16'h0000, 0);
    wait_clk(8);
    check({power_down_o, busy_o}, 2'b10);
  endtask

  // Second reset in mid-run stops the sequence and brings masks, length, busy, data valid and power-down back to zero
  task automatic t_rereset();
    start_seq();
    check(busy_o, 1);
    @(negedge clk_i) reset_n_i = 1'b0;
    wait_clk(4);
    reset_n_i = 1'b1;
    wait_clk(6);
    t_reset();
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    reset_n_i = 1'b0;
    wait_clk(4);
    reset_n_i = 1'b1;
    wait_clk(6);
    t_reset();
    t_config();
    t_run();
    t_midcfg();
    t_midmode();
    t_rereset();
    report_and_stop();
  end
endmodule
`default_nettype wire
